// >>> mcadc_consts.svh
`ifndef MCADC_CONSTS_SVH
`define MCADC_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define MCADC_IDX_SELECT      6'h0D
`define MCADC_IDX_VBAT        6'h0F
`define MCADC_IDX_VCHG        6'h10
`define MCADC_IDX_ICHG        6'h11
`define MCADC_IDX_STATUS      6'h18
`define MCADC_IDX_START       6'h20
`define MCADC_IDX_IRQ_STAT    6'h21
`define MCADC_IDX_IRQ_MASK    6'h22

// ----------------------------------------------------------------
// channel numbers, equal to their select bit positions
// ----------------------------------------------------------------
`define MCADC_CH_VBAT         3'h0
`define MCADC_CH_VCHG         3'h1
`define MCADC_CH_ICHG         3'h2
`define MCADC_CH_VBKP         3'h3
`define MCADC_CH_AUX1         3'h4
`define MCADC_CH_AUX2         3'h5
`define MCADC_CH_AUX3         3'h6
`define MCADC_CH_AUX4         3'h7
`define MCADC_CH_LAST         3'h7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MCADC_BUSY_BIT        0
`define MCADC_START_BIT       0
`define MCADC_IRQ_DONE_BIT    0
`define MCADC_IRQ_REFUSED_BIT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MCADC_SELECT_RST      8'h00
`define MCADC_IRQ_RST         2'h0
`define MCADC_READDATA_RST    32'h0000_0000

`endif

// >>> mcadc_pkg.sv
package mcadc_pkg;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ISSUE,
		SEQ_WAIT
	} mcadc_seq_type;

	typedef logic [7:0] mcadc_sel_type;
	typedef logic [2:0] mcadc_chan_type;
	typedef logic [1:0] mcadc_irq_type;

endpackage : mcadc_pkg

// >>> mcadc_result_reg.sv
`timescale 1ns/100ps
`include "mcadc_consts.svh"

module mcadc_result_reg #(
	parameter int RESULT_W = 10
) (
	input  wire logic                mclk, // system clock
	input  wire logic                rst,  // synchronous reset
	input  wire logic                ce,   // clock enable
	input  wire logic                load, // capture din
	input  wire logic [RESULT_W-1:0] din,  // conversion result
	output logic      [RESULT_W-1:0] dout  // held result
);
	logic [RESULT_W-1:0] value_reg;
	logic [RESULT_W-1:0] value_next;

	always_comb begin
		value_next = load ? din : value_reg;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			value_reg <= '0;
		end else if (ce) begin
			value_reg <= value_next;
		end
	end

	assign dout = value_reg;

endmodule : mcadc_result_reg

// >>> mcadc_top.sv
// Contract
// - select bits 7..4 schedule aux inputs 4..1 for the next sequence.
// - select bits 3..0 schedule backup, charger current, charger voltage, main battery.
// - status bit 0 reads one while converting, zero otherwise; other bits reserved.
// - main battery 10-bit result sits in a read-only register; writes ignored.
// - charger voltage 10-bit result sits in a read-only register.
// - charger current 10-bit result sits in a read-only register.
// - select writes land in shadow; shadow copies to master on request.
// - select reads return the master copy.
// - select writes during a sequence change only the shadow.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "mcadc_consts.svh"

module mcadc_top #(
	parameter int RESULT_W = 10
) (
	input  wire logic                    mclk,            // 50 MHz clock
	input  wire logic                    rst,             // synchronous reset, high
	input  wire logic                    ce,              // clock enable
	input  wire logic [7:0]              avs_address,     // byte address
	input  wire logic                    avs_read,        // read request
	input  wire logic                    avs_write,       // write request
	input  wire logic [31:0]             avs_writedata,   // write data
	input  wire logic [3:0]              avs_byteenable,  // byte lanes
	output logic      [31:0]             avs_readdata,    // read data
	output logic                         avs_waitrequest, // stall
	output logic                         conv_start,      // start one conversion
	output mcadc_pkg::mcadc_chan_type    conv_channel,    // channel to convert
	input  wire logic                    conv_done,       // conversion finished
	input  wire logic [RESULT_W-1:0]     conv_data,       // conversion result
	output logic                         busy,            // sequence running
	output logic                         irq              // interrupt level
);
	import mcadc_pkg::*;

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	generate
		if (RESULT_W < 1 || RESULT_W > 32) begin : g_bad_width
			$error("mcadc_top: RESULT_W must be 1 to 32");
		end
	endgenerate

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic          wait_reg;
	logic          wait_next;
	logic [31:0]   rdata_reg;
	logic [31:0]   rdata_next;
	mcadc_seq_type state_reg;
	mcadc_seq_type state_next;
	mcadc_chan_type chan_reg;
	mcadc_chan_type chan_next;
	mcadc_sel_type shadow_reg;
	mcadc_sel_type shadow_next;
	mcadc_sel_type active_reg;
	mcadc_sel_type active_next;
	logic          busy_reg;
	logic          busy_next;
	logic          start_reg;
	logic          start_next;
	mcadc_chan_type cchan_reg;
	mcadc_chan_type cchan_next;
	mcadc_irq_type irq_stat_reg;
	mcadc_irq_type irq_stat_next;
	mcadc_irq_type irq_mask_reg;
	mcadc_irq_type irq_mask_next;
	logic          irq_reg;
	logic          irq_next;
	logic          conv_open_reg;
	logic          conv_open_next;

	logic                req;
	logic                rd_acc;
	logic                wr_acc;
	logic                hit;
	logic [5:0]          idx;
	logic                start_req;
	logic                done_evt;
	logic                refused_evt;
	logic                load_vbat;
	logic                load_vchg;
	logic                load_ichg;
	logic [RESULT_W-1:0] vbat_q;
	logic [RESULT_W-1:0] vchg_q;
	logic [RESULT_W-1:0] ichg_q;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign idx       = avs_address[7:2];
	assign hit       = (avs_address[1:0] == 2'h0);
	assign req       = avs_read | avs_write;
	assign rd_acc    = avs_read && !wait_reg;
	assign wr_acc    = avs_write && !wait_reg && avs_byteenable[0] && hit;
	assign start_req = wr_acc && (idx == `MCADC_IDX_START) && avs_writedata[`MCADC_START_BIT];

	always_comb begin
		// one wait cycle, then a single accept cycle
		wait_next  = !(req && wait_reg);
		rdata_next = rdata_reg;
		if (avs_read && wait_reg) begin
			rdata_next = `MCADC_READDATA_RST;
			if (hit) begin
				case (idx)
					`MCADC_IDX_SELECT:   rdata_next[7:0] = active_reg;
					`MCADC_IDX_VBAT:     rdata_next[RESULT_W-1:0] = vbat_q;
					`MCADC_IDX_VCHG:     rdata_next[RESULT_W-1:0] = vchg_q;
					`MCADC_IDX_ICHG:     rdata_next[RESULT_W-1:0] = ichg_q;
					`MCADC_IDX_STATUS:   rdata_next[`MCADC_BUSY_BIT] = busy_reg;
					`MCADC_IDX_START:    rdata_next[`MCADC_START_BIT] = busy_reg;
					`MCADC_IDX_IRQ_STAT: rdata_next[1:0] = irq_stat_reg;
					`MCADC_IDX_IRQ_MASK: rdata_next[1:0] = irq_mask_reg;
					default:             rdata_next = `MCADC_READDATA_RST;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// shadow and sequencer
	// ----------------------------------------------------------------
	always_comb begin
		shadow_next = shadow_reg;
		active_next = active_reg;
		state_next  = state_reg;
		chan_next   = chan_reg;
		busy_next   = busy_reg;
		start_next  = 1'b0;
		cchan_next  = cchan_reg;
		done_evt    = 1'b0;
		refused_evt = 1'b0;
		conv_open_next = conv_open_reg;
		// writes touch only the shadow, even mid-sequence
		if (wr_acc && idx == `MCADC_IDX_SELECT) begin
			shadow_next = avs_writedata[7:0];
		end
		case (state_reg)
			SEQ_IDLE: begin
				if (start_req) begin
					active_next = shadow_reg;
					busy_next   = 1'b1;
					chan_next   = `MCADC_CH_VBAT;
					state_next  = SEQ_ISSUE;
				end
			end
			SEQ_ISSUE: begin
				if (active_reg[chan_reg]) begin
					start_next = 1'b1;
					cchan_next = chan_reg;
					state_next = SEQ_WAIT;
				end else if (chan_reg == `MCADC_CH_LAST) begin
					busy_next  = 1'b0;
					done_evt   = 1'b1;
					state_next = SEQ_IDLE;
				end else begin
					chan_next = chan_reg + 3'h1;
				end
			end
			SEQ_WAIT: begin
				if (conv_done) begin
					if (chan_reg == `MCADC_CH_LAST) begin
						busy_next  = 1'b0;
						done_evt   = 1'b1;
						state_next = SEQ_IDLE;
					end else begin
						chan_next  = chan_reg + 3'h1;
						state_next = SEQ_ISSUE;
					end
				end
			end
			default: begin
				state_next = SEQ_IDLE;
				busy_next  = 1'b0;
			end
		endcase
		if (start_req && state_reg != SEQ_IDLE) begin
			refused_evt = 1'b1;
		end
		// one conversion open from its start pulse to its done
		if (start_reg) begin
			conv_open_next = 1'b1;
		end else if (conv_done) begin
			conv_open_next = 1'b0;
		end
	end

	// result loads; host reads them once busy is clear
	assign load_vbat = (state_reg == SEQ_WAIT) && conv_done && (chan_reg == `MCADC_CH_VBAT);
	assign load_vchg = (state_reg == SEQ_WAIT) && conv_done && (chan_reg == `MCADC_CH_VCHG);
	assign load_ichg = (state_reg == SEQ_WAIT) && conv_done && (chan_reg == `MCADC_CH_ICHG);

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	always_comb begin
		irq_stat_next = irq_stat_reg;
		irq_mask_next = irq_mask_reg;
		if (rd_acc && hit && idx == `MCADC_IDX_IRQ_STAT) begin
			irq_stat_next = `MCADC_IRQ_RST;
		end
		// set wins over the read clear
		irq_stat_next[`MCADC_IRQ_DONE_BIT]    = irq_stat_next[`MCADC_IRQ_DONE_BIT] | done_evt;
		irq_stat_next[`MCADC_IRQ_REFUSED_BIT] = irq_stat_next[`MCADC_IRQ_REFUSED_BIT] | refused_evt;
		if (wr_acc && idx == `MCADC_IDX_IRQ_MASK) begin
			irq_mask_next = avs_writedata[1:0];
		end
		irq_next = |(irq_stat_next & irq_mask_next);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			wait_reg     <= 1'b1;
			rdata_reg    <= `MCADC_READDATA_RST;
			state_reg    <= SEQ_IDLE;
			chan_reg     <= `MCADC_CH_VBAT;
			shadow_reg   <= `MCADC_SELECT_RST;
			active_reg   <= `MCADC_SELECT_RST;
			busy_reg     <= 1'b0;
			start_reg    <= 1'b0;
			cchan_reg    <= `MCADC_CH_VBAT;
			irq_stat_reg <= `MCADC_IRQ_RST;
			irq_mask_reg <= `MCADC_IRQ_RST;
			irq_reg      <= 1'b0;
			conv_open_reg <= 1'b0;
		end else if (ce) begin
			wait_reg     <= wait_next;
			rdata_reg    <= rdata_next;
			state_reg    <= state_next;
			chan_reg     <= chan_next;
			shadow_reg   <= shadow_next;
			active_reg   <= active_next;
			busy_reg     <= busy_next;
			start_reg    <= start_next;
			cchan_reg    <= cchan_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			irq_reg      <= irq_next;
			conv_open_reg <= conv_open_next;
		end
	end

	// ----------------------------------------------------------------
	// result registers
	// ----------------------------------------------------------------
	mcadc_result_reg #(.RESULT_W(RESULT_W)) u_vbat (
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.load (load_vbat),
		.din  (conv_data),
		.dout (vbat_q)
	);

	mcadc_result_reg #(.RESULT_W(RESULT_W)) u_vchg (
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.load (load_vchg),
		.din  (conv_data),
		.dout (vchg_q)
	);

	mcadc_result_reg #(.RESULT_W(RESULT_W)) u_ichg (
		.mclk (mclk),
		.rst  (rst),
		.ce   (ce),
		.load (load_ichg),
		.din  (conv_data),
		.dout (ichg_q)
	);

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign conv_start      = start_reg;
	assign conv_channel    = cchan_reg;
	assign busy            = busy_reg;
	assign irq             = irq_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst || !ce);

	a_issue_aux_only: assert property (start_reg && cchan_reg >= `MCADC_CH_AUX1 |-> active_reg[cchan_reg])
		else $error("aux conversion issued for unselected input");
	a_issue_meas_only: assert property (start_reg && cchan_reg <= `MCADC_CH_VBKP |-> active_reg[cchan_reg])
		else $error("measurement issued while not selected");
	a_status_busy_bit: assert property (rd_acc && hit && idx == `MCADC_IDX_STATUS |->
		avs_readdata == {31'h0, $past(busy_reg)})
		else $error("status read does not show busy");
	a_vbat_capture: assert property (load_vbat |=> vbat_q == $past(conv_data))
		else $error("main battery result not captured");
	a_vbat_write_ignored: assert property (wr_acc && idx == `MCADC_IDX_VBAT && !load_vbat |=> $stable(vbat_q))
		else $error("write altered main battery result");
	a_vchg_capture: assert property (load_vchg |=> vchg_q == $past(conv_data))
		else $error("charger voltage result not captured");
	a_ichg_capture: assert property (load_ichg |=> ichg_q == $past(conv_data))
		else $error("charger current result not captured");
	a_start_copies_shadow: assert property (start_req && state_reg == SEQ_IDLE |=>
		active_reg == $past(shadow_reg) && busy_reg)
		else $error("request did not copy shadow to master");
	a_select_reads_master: assert property (rd_acc && hit && idx == `MCADC_IDX_SELECT |->
		avs_readdata == {24'h0, $past(active_reg)})
		else $error("select read does not return master");
	a_master_held_busy: assert property (busy_reg && $past(busy_reg) |-> $stable(active_reg))
		else $error("master changed during sequence");
	a_busy_ends_last: assert property ($fell(busy_reg) |-> $past(chan_reg) == `MCADC_CH_LAST)
		else $error("busy cleared before last channel");
	a_one_at_a_time: assert property (start_reg |-> !conv_open_reg)
		else $error("second conversion issued while waiting");

	c_seq_done:     cover property ($fell(busy_reg));
	c_write_busy:   cover property (busy_reg && wr_acc && idx == `MCADC_IDX_SELECT);
	c_ichg_loaded:  cover property (load_ichg);
	c_status_clear: cover property (rd_acc && hit && idx == `MCADC_IDX_IRQ_STAT && irq_stat_reg != 2'h0);

endmodule : mcadc_top

// >>> mcadc_conv_model.sv
`timescale 1ns/100ps

// ----------------------------------------------------------------
// converter stand-in: one conversion per start pulse
// ----------------------------------------------------------------
module mcadc_conv_model (
	input  wire logic       mclk,         // system clock
	input  wire logic       rst,          // synchronous reset
	input  wire logic       slow,         // long conversion latency
	input  wire logic       conv_start,   // start one conversion
	input  wire logic [2:0] conv_channel, // channel to convert
	output logic            conv_done,    // result pulse
	output logic      [9:0] conv_data     // result, valid with done only
);
	logic       pend;
	logic [3:0] cnt;
	logic [2:0] ch;

	always @(posedge mclk) begin
		if (rst) begin
			pend      <= 1'b0;
			cnt       <= 4'h0;
			ch        <= 3'h0;
			conv_done <= 1'b0;
			conv_data <= 10'h3FF;
		end else begin
			if (conv_start) begin
				pend <= 1'b1;
				ch   <= conv_channel;
				cnt  <= slow ? 4'h9 : 4'h1;
			end
			if (pend && !conv_start && cnt == 4'h0) begin
				pend      <= 1'b0;
				conv_done <= 1'b1;
				conv_data <= {ch, 7'h2A};
			end else begin
				conv_done <= 1'b0;
				// data released outside the done cycle: keep it moving
				conv_data <= ~conv_data;
				if (pend && !conv_start) begin
					cnt <= cnt - 4'h1;
				end
			end
		end
	end
endmodule : mcadc_conv_model

// >>> mcadc_tb_top.sv
`timescale 1ns/100ps

module mcadc_tb_top;
	import mcadc_pkg::*;

	logic           mclk;
	logic           rst;
	logic           slow;
	logic [7:0]     avs_address;
	logic           avs_read;
	logic           avs_write;
	logic [31:0]    avs_writedata;
	logic [31:0]    avs_readdata;
	logic           avs_waitrequest;
	logic           conv_start;
	mcadc_chan_type conv_channel;
	logic           conv_done;
	logic [9:0]     conv_data;
	logic           busy;
	logic           irq;
	logic [31:0]    rd;
	logic [7:0]     seen;
	logic           clr_rec;
	logic [3:0]     be;
	logic           order_bad;
	logic [2:0]     last_ch;
	int             num_errors;
	int             tests_run;
	logic [7:0]     zero_addr [9] = '{8'h34, 8'h3C, 8'h40, 8'h44, 8'h60, 8'h84, 8'h88, 8'h04, 8'h35};

	mcadc_top u_mcadc_top (.mclk(mclk), .rst(rst), .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .conv_start(conv_start), .conv_channel(conv_channel),
		.conv_done(conv_done), .conv_data(conv_data), .busy(busy), .irq(irq));

	mcadc_conv_model u_mcadc_conv_model (.mclk(mclk), .rst(rst), .slow(slow), .conv_start(conv_start),
		.conv_channel(conv_channel), .conv_done(conv_done), .conv_data(conv_data));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// record which channels a sequence converted, and in what order
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		if (rst || clr_rec) begin
			seen      <= 8'h00;
			order_bad <= 1'b0;
			last_ch   <= 3'h0;
		end else if (conv_start === 1'b1) begin
			if (seen != 8'h00 && conv_channel <= last_ch) order_bad <= 1'b1;
			seen[conv_channel] <= 1'b1;
			last_ch            <= conv_channel;
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic finish_test;
		if (num_errors == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr_en;
		avs_read      <= ~wr_en;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) begin
			n++;
			if (n > 20) begin
				num_errors++;
				finish_test();
			end
			@(posedge mclk);
		end
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge mclk);
	endtask : bus

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rd_chk

	task automatic start;
		clr_rec <= 1'b1;
		@(posedge mclk);
		clr_rec <= 1'b0;
		bus(1'b1, 8'h80, 32'h1);
	endtask : start

	// results only trusted once busy reads clear
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			bus(1'b0, 8'h60, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 100);
		if (n >= 100) begin
			num_errors++;
			finish_test();
		end
	endtask : wait_idle

	function automatic logic [31:0] res(input logic [2:0] ch);
		return {22'h0, ch, 7'h2A};
	endfunction : res

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst           = 1'b1;
		slow          = 1'b1;
		avs_address   = 8'h00;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0;
		clr_rec       = 1'b0;
		be            = 4'hF;
		num_errors    = 0;
		tests_run     = 0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		// reset values, unmapped and misaligned places
		foreach (zero_addr[i]) rd_chk(zero_addr[i], 32'h0);
		bus(1'b1, 8'h88, 32'h3);
		rd_chk(8'h88, 32'h3);
		// staged selection with a slow converter
		bus(1'b1, 8'h34, 32'h07);
		rd_chk(8'h34, 32'h0);
		start();
		check({31'h0, busy}, 32'h1);
		rd_chk(8'h80, 32'h1);
		rd_chk(8'h60, 32'h1);
		rd_chk(8'h34, 32'h07);
		bus(1'b1, 8'h34, 32'hF8);
		rd_chk(8'h34, 32'h07);
		bus(1'b1, 8'h80, 32'h1);
		wait_idle();
		check({31'h0, busy}, 32'h0);
		check({24'h0, seen}, 32'h07);
		check({31'h0, order_bad}, 32'h0);
		rd_chk(8'h3C, res(3'h0));
		rd_chk(8'h40, res(3'h1));
		rd_chk(8'h44, res(3'h2));
		repeat (3) @(posedge mclk);
		check({31'h0, irq}, 32'h1);
		rd_chk(8'h84, 32'h3);
		repeat (3) @(posedge mclk);
		check({31'h0, irq}, 32'h0);
		rd_chk(8'h84, 32'h0);
		// result and status writes ignored
		bus(1'b1, 8'h3C, 32'h3FF);
		rd_chk(8'h3C, res(3'h0));
		bus(1'b1, 8'h60, 32'h1);
		rd_chk(8'h60, 32'h0);
		// aux inputs and backup only, prompt converter
		slow <= 1'b0;
		start();
		rd_chk(8'h34, 32'hF8);
		wait_idle();
		check({24'h0, seen}, 32'hF8);
		check({31'h0, order_bad}, 32'h0);
		rd_chk(8'h40, res(3'h1));
		// every channel, reserved bits dropped, interrupt masked off
		bus(1'b1, 8'h88, 32'h0);
		be <= 4'hE;
		bus(1'b1, 8'h88, 32'h3);
		be <= 4'hF;
		rd_chk(8'h88, 32'h0);
		bus(1'b1, 8'h34, 32'h3FF);
		start();
		wait_idle();
		check({24'h0, seen}, 32'hFF);
		check({31'h0, order_bad}, 32'h0);
		rd_chk(8'h34, 32'hFF);
		repeat (3) @(posedge mclk);
		check({31'h0, irq}, 32'h0);
		rd_chk(8'h84, 32'h1);
		// empty selection still completes
		bus(1'b1, 8'h34, 32'h0);
		start();
		wait_idle();
		check({24'h0, seen}, 32'h0);
		rd_chk(8'h34, 32'h0);
		finish_test();
	end
endmodule : mcadc_tb_top
